// ==== design/irq_tick_pkg.sv ====
// shared constants and types for the interrupt and time base unit
package irq_tick_pkg;

  // --------------------------------------------------------------
  // register offsets
  // --------------------------------------------------------------
  localparam logic [7:0] TICK_CTRL_OFS   = 8'h00;
  localparam logic [7:0] PRESCALER_OFS   = 8'h01;
  localparam logic [7:0] INT_EN_OFS      = 8'h02;
  localparam logic [7:0] INT_FLAG_OFS    = 8'h03;

  // --------------------------------------------------------------
  // field positions and reset values
  // --------------------------------------------------------------
  localparam int         TICK_RUN_BIT    = 7;
  localparam int         TICK_SEL_HI     = 2;
  localparam int         PSC_SEL_HI      = 1;
  localparam logic [7:0] TICK_CTRL_RST   = 8'h00;
  localparam logic [1:0] PSC_SEL_RST     = 2'h0;
  localparam logic [6:0] INT_EN_RST      = 7'h00;
  localparam logic [5:0] INT_FLAG_RST    = 6'h00;

  // --------------------------------------------------------------
  // time base figures
  // --------------------------------------------------------------
  localparam logic [15:0] TICK_BASE_PERIOD = 16'h0100;
  localparam logic [1:0]  SYS_DIV4_LAST    = 2'h3;
  localparam logic [1:0]  PSC_SYS          = 2'h0;
  localparam logic [1:0]  PSC_SYS_DIV4     = 2'h1;

  // --------------------------------------------------------------
  // request flags, one per source; bit order is also the priority
  // --------------------------------------------------------------
  typedef struct packed {
    logic group;
    logic tick;
    logic nvm;
    logic twowire;
    logic serial;
    logic lowsupply;
  } req_t;

  // enables: per-source enables above the global enable in bit 0
  typedef struct packed {
    req_t src;
    logic global_int_en;
  } en_t;

  typedef enum logic [2:0] {
    VEC_LOWSUPPLY,
    VEC_SERIAL,
    VEC_TWOWIRE,
    VEC_NVM,
    VEC_TICK,
    VEC_GROUP,
    VEC_NONE
  } vec_t;

endpackage

// ==== design/irq_tick_unit.sv ====
// interrupt request, vectoring, wake-up and periodic time base logic
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/1ns

// Function
// - tick_run bit starts and stops time base
// - tick control bits six to three read zero
// - period is 2^(8+sel) prescaled clock cycles
// - low supply sets flag; vectors when enabled
// - low supply service clears flag and global
// - any serial condition raises serial request
// - serial conditions arrive as low-going pulses
// - serial service clears flag and global only
// - two-wire byte, match, time-out set flag
// - two-wire service clears flag and global
// - nvm erase or write done sets flag
// - nvm service clears flag and global
// - vector needs enable, global, free stack
// - any flag rising edge wakes the device
// - flags hold until serviced or cleared
// - service clears group flag, software sources
// - only program counter pushed on service
// - interrupt return sets global, plain return not
// - prescaler selects sys, sys/4 or subclock
// - overflow sets tick flag; service clears
module irq_tick_unit (
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  input  wire logic [7:0]  ADDR,
  input  wire logic [7:0]  WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [7:0]  RDATA,
  input  wire logic        LOW_SUPPLY,
  input  wire logic        SERIAL_EVT_N,
  input  wire logic        TWOWIRE_EVT,
  input  wire logic        NVM_DONE,
  input  wire logic        GROUP_EVT,
  input  wire logic        SUB_TICK,
  input  wire logic        CORE_READY,
  input  wire logic        STACK_FULL,
  input  wire logic        RET_INT,
  output logic             VEC_TAKE,
  output logic             PUSH_PC,
  output logic      [2:0]  VEC_ID,
  output logic             WAKE
);

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  logic                    tick_run_reg;
  logic [2:0]              tick_period_sel_reg;
  logic [1:0]              prescaler_src_sel_reg;
  irq_tick_pkg::en_t       en_reg;
  irq_tick_pkg::en_t       en_next;
  irq_tick_pkg::req_t      flag_reg;
  irq_tick_pkg::req_t      flag_next;
  irq_tick_pkg::req_t      flag_prev_reg;
  irq_tick_pkg::req_t      set_evt;
  irq_tick_pkg::req_t      pend;
  irq_tick_pkg::vec_t      sel_vec;
  logic                    take;
  logic                    serial_prev_reg;
  logic [1:0]              div4_reg;
  logic                    prescaled_clock;
  logic [14:0]             tick_cnt_reg;
  logic [15:0]             tick_last;
  logic                    tick_ovf;
  logic                    wr_tick;
  logic                    wr_psc;
  logic                    wr_en;
  logic                    wr_flag;

  // --------------------------------------------------------------
  // register decode
  // --------------------------------------------------------------
  always_comb begin
    wr_tick = 1'b0;
    wr_psc  = 1'b0;
    wr_en   = 1'b0;
    wr_flag = 1'b0;
    if (WR && ADDR == irq_tick_pkg::TICK_CTRL_OFS) begin
      wr_tick = 1'b1;
    end else if (WR && ADDR == irq_tick_pkg::PRESCALER_OFS) begin
      wr_psc = 1'b1;
    end else if (WR && ADDR == irq_tick_pkg::INT_EN_OFS) begin
      wr_en = 1'b1;
    end else if (WR && ADDR == irq_tick_pkg::INT_FLAG_OFS) begin
      wr_flag = 1'b1;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      tick_run_reg        <= irq_tick_pkg::TICK_CTRL_RST[irq_tick_pkg::TICK_RUN_BIT];
      tick_period_sel_reg <= irq_tick_pkg::TICK_CTRL_RST[irq_tick_pkg::TICK_SEL_HI:0];
    end else if (wr_tick) begin
      tick_run_reg        <= WDATA[irq_tick_pkg::TICK_RUN_BIT];
      tick_period_sel_reg <= WDATA[irq_tick_pkg::TICK_SEL_HI:0];
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      prescaler_src_sel_reg <= irq_tick_pkg::PSC_SEL_RST;
    end else if (wr_psc) begin
      prescaler_src_sel_reg <= WDATA[irq_tick_pkg::PSC_SEL_HI:0];
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      RDATA <= 8'h00;
    end else if (!RD) begin
      RDATA <= 8'h00;
    end else if (ADDR == irq_tick_pkg::TICK_CTRL_OFS) begin
      RDATA <= {tick_run_reg, 4'h0, tick_period_sel_reg};
    end else if (ADDR == irq_tick_pkg::PRESCALER_OFS) begin
      RDATA <= {6'h00, prescaler_src_sel_reg};
    end else if (ADDR == irq_tick_pkg::INT_EN_OFS) begin
      RDATA <= {1'b0, en_reg};
    end else if (ADDR == irq_tick_pkg::INT_FLAG_OFS) begin
      RDATA <= {2'h0, flag_reg};
    end else begin
      RDATA <= 8'h00;
    end
  end

  // --------------------------------------------------------------
  // time base
  // --------------------------------------------------------------
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      div4_reg <= 2'h0;
    end else begin
      div4_reg <= div4_reg + 2'h1;
    end
  end

  // prescaler source select; subclock arrives as a tick strobe
  always_comb begin
    if (prescaler_src_sel_reg == irq_tick_pkg::PSC_SYS) begin
      prescaled_clock = 1'b1;
    end else if (prescaler_src_sel_reg == irq_tick_pkg::PSC_SYS_DIV4) begin
      prescaled_clock = (div4_reg == irq_tick_pkg::SYS_DIV4_LAST);
    end else begin
      prescaled_clock = SUB_TICK;
    end
  end

  // last count of the selected period
  assign tick_last = (irq_tick_pkg::TICK_BASE_PERIOD << tick_period_sel_reg) - 16'h0001;
  assign tick_ovf  = tick_run_reg && prescaled_clock && ({1'b0, tick_cnt_reg} == tick_last);

  // counter held at zero while stopped, so a restart gives a full period
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      tick_cnt_reg <= 15'h0000;
    end else if (!tick_run_reg || tick_ovf) begin
      tick_cnt_reg <= 15'h0000;
    end else if (prescaled_clock) begin
      tick_cnt_reg <= tick_cnt_reg + 15'h0001;
    end
  end

  // --------------------------------------------------------------
  // request sources
  // --------------------------------------------------------------
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      serial_prev_reg <= 1'b1;
    end else begin
      serial_prev_reg <= SERIAL_EVT_N;
    end
  end

  always_comb begin
    // flag follows a low supply report
    set_evt.lowsupply = LOW_SUPPLY;
    // the serial port ORs its conditions into one low pulse
    set_evt.serial    = serial_prev_reg && !SERIAL_EVT_N;
    // byte done, address match or time-out
    set_evt.twowire   = TWOWIRE_EVT;
    set_evt.nvm       = NVM_DONE;
    set_evt.tick      = tick_ovf;
    set_evt.group     = GROUP_EVT;
  end

  // --------------------------------------------------------------
  // arbitration
  // --------------------------------------------------------------
  assign pend = flag_reg & en_reg.src;

  // lowest bit wins; others stay pending
  always_comb begin
    sel_vec = irq_tick_pkg::VEC_NONE;
    for (int i = 5; i >= 0; i--) begin
      if (pend[i]) begin
        sel_vec = irq_tick_pkg::vec_t'(i[2:0]);
      end
    end
  end

  // source enable, global enable and a free stack entry
  assign take = CORE_READY && en_reg.global_int_en && !STACK_FULL &&
                (sel_vec != irq_tick_pkg::VEC_NONE);

  // flags hold; a hardware set wins over any clear in the same cycle
  always_comb begin
    flag_next = flag_reg;
    if (wr_flag) begin
      // software may also preset a flag to mask its wake-up
      flag_next = irq_tick_pkg::req_t'(WDATA[5:0]);
    end
    if (take) begin
      flag_next[sel_vec] = 1'b0;
    end
    flag_next = flag_next | set_evt;
  end

  always_comb begin
    en_next = en_reg;
    if (wr_en) begin
      en_next = irq_tick_pkg::en_t'(WDATA[6:0]);
    end
    if (take) begin
      en_next.global_int_en = 1'b0;
    end
    // interrupt return reopens; a plain return is not seen here
    if (RET_INT) begin
      en_next.global_int_en = 1'b1;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      flag_reg      <= irq_tick_pkg::INT_FLAG_RST;
      flag_prev_reg <= irq_tick_pkg::INT_FLAG_RST;
    end else begin
      flag_reg      <= flag_next;
      flag_prev_reg <= flag_reg;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      en_reg <= irq_tick_pkg::INT_EN_RST;
    end else begin
      en_reg <= en_next;
    end
  end

  // --------------------------------------------------------------
  // core side
  // --------------------------------------------------------------
  // one push request, program counter only
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      VEC_TAKE <= 1'b0;
      PUSH_PC  <= 1'b0;
      VEC_ID   <= irq_tick_pkg::VEC_NONE;
    end else begin
      VEC_TAKE <= take;
      PUSH_PC  <= take;
      VEC_ID   <= take ? sel_vec : irq_tick_pkg::VEC_NONE;
    end
  end

  // wake on any rising flag, enables ignored
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      WAKE <= 1'b0;
    end else begin
      WAKE <= |(flag_reg & ~flag_prev_reg);
    end
  end

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  a_reserved_read_zero: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    (RD && ADDR == irq_tick_pkg::TICK_CTRL_OFS) |=> (RDATA[6:3] == 4'h0))
    else $error("tick control reserved bits not zero");

  a_stopped_counter_zero: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    (!tick_run_reg && !wr_tick) |=> (tick_cnt_reg == 15'h0000))
    else $error("time base counter not held while stopped");

  a_overflow_sets_flag: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    tick_ovf |=> flag_reg.tick)
    else $error("overflow did not set tick flag");

  a_lowsupply_sets_flag: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    LOW_SUPPLY |=> flag_reg.lowsupply)
    else $error("low supply did not set flag");

  a_serial_pulse_flag: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    $fell(SERIAL_EVT_N) |=> flag_reg.serial)
    else $error("serial low pulse did not set flag");

  a_no_take_full: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    (STACK_FULL || !en_reg.global_int_en) |=> !VEC_TAKE)
    else $error("vector taken without global enable or stack room");

  a_take_clears_global: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    (take && !RET_INT && !wr_en) |=> (!en_reg.global_int_en && VEC_TAKE && PUSH_PC
                                      && VEC_ID == $past(sel_vec)))
    else $error("service did not clear global enable or signal vector");

  a_return_from_interrupt_sets_global: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    RET_INT |=> en_reg.global_int_en)
    else $error("interrupt return did not set global enable");

  a_wake_on_rise: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    (|(flag_reg & ~flag_prev_reg)) |=> WAKE)
    else $error("rising flag gave no wake");

endmodule

// ==== verif/core_seq_model.sv ====
// core sequencer and return stack model facing the interrupt unit
`timescale 1ns/1ns
module core_seq_model #(
  parameter int DEPTH = 8
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic push_pc,
  input  wire logic slow,
  input  wire logic ret_req,
  input  wire logic nest_fill,
  output logic      core_ready,
  output logic      stack_full,
  output logic      ret_int
);
  logic [3:0] depth;
  logic       phase;
  // ------------------------------------------
  // return stack
  // ------------------------------------------
  // pushes fill the stack
  // nest_fill stands in for software calls nested to the limit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      depth <= 4'h0;
    end else if (nest_fill) begin
      depth <= 4'(DEPTH);
    end else if (push_pc && !stack_full) begin
      depth <= depth + 4'h1;
    end else if (ret_int) begin
      depth <= depth - 4'h1;
    end
  end
  assign stack_full = (depth == 4'(DEPTH));
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ret_int <= 1'b0;
      phase   <= 1'b0;
    end else begin
      ret_int <= ret_req && (depth != 4'h0);
      phase   <= ~phase;
    end
  end
  // a slow core is ready only every other cycle, which delays takes
  assign core_ready = !slow || phase;
endmodule

// ==== verif/test_interrupt_and_time_base_unit.sv ====
// self-checking bench for the interrupt and time base unit
`timescale 1ns/1ns
module test_interrupt_and_time_base_unit;
  logic       CLK, SYS_RST, WR, RD, slow, ret_req, nest_fill;
  logic       SUB_TICK = 1'b0;
  logic [7:0] ADDR, WDATA, RDATA;
  logic [5:0] ev;
  logic [2:0] sub_cnt = 3'h0;
  logic       CORE_READY, STACK_FULL, RET_INT, VEC_TAKE, PUSH_PC, WAKE;
  logic [2:0] VEC_ID;
  int         mismatches = 0;
  int         n_checks = 0;
  // --------------------------------------------------------------
  // wiring
  // --------------------------------------------------------------
  irq_tick_unit dut (.CLK(CLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .LOW_SUPPLY(ev[0]), .SERIAL_EVT_N(~ev[1]), .TWOWIRE_EVT(ev[2]),
    .NVM_DONE(ev[3]), .GROUP_EVT(ev[5]), .SUB_TICK(SUB_TICK), .CORE_READY(CORE_READY),
    .STACK_FULL(STACK_FULL), .RET_INT(RET_INT), .VEC_TAKE(VEC_TAKE), .PUSH_PC(PUSH_PC),
    .VEC_ID(VEC_ID), .WAKE(WAKE));
  core_seq_model core (.clk(CLK), .rst(SYS_RST), .push_pc(PUSH_PC), .slow(slow),
    .ret_req(ret_req), .nest_fill(nest_fill), .core_ready(CORE_READY),
    .stack_full(STACK_FULL), .ret_int(RET_INT));
  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end
  // subclock strobe, one cycle in eight
  always @(posedge CLK) begin
    sub_cnt  <= sub_cnt + 3'h1;
    SUB_TICK <= (sub_cnt == 3'h7);
  end
  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge CLK);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 chk(RDATA, exp);
  endtask
  task automatic pulse(input int k);
    @(posedge CLK);
    ev[k] <= 1'b1;
    @(posedge CLK);
    ev[k] <= 1'b0;
  endtask
  // fill = 1 nests calls to the stack limit, else an interrupt return
  task automatic core_cmd(input bit fill);
    @(posedge CLK);
    if (fill) nest_fill <= 1'b1;
    else ret_req <= 1'b1;
    @(posedge CLK);
    nest_fill <= 1'b0;
    ret_req   <= 1'b0;
  endtask
  task automatic wait_vec(input logic [2:0] id, input int lim, output int n);
    n = 0;
    do begin
      @(posedge CLK);
      #1 n++;
    end while (VEC_TAKE !== 1'b1 && n < lim);
    chk({5'h0, VEC_ID}, {5'h0, id});
    chk({6'h0, VEC_TAKE, PUSH_PC}, 8'h03);
  endtask
  task automatic watch(input int nc, output logic v, output logic w);
    v = 1'b0;
    w = 1'b0;
    repeat (nc) begin
      @(posedge CLK);
      #1 v = v | (VEC_TAKE === 1'b1);
      w = w | (WAKE === 1'b1);
    end
  endtask
  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic t_regs;
    for (int a = 0; a < 4; a++) rdc(8'(a), 8'h00);
    wr(8'h00, 8'hFF);
    rdc(8'h00, 8'h87);
    wr(8'h00, 8'h00);
    wr(8'h01, 8'hFF);
    rdc(8'h01, 8'h03);
    wr(8'h20, 8'h5A);
    rdc(8'h20, 8'h00);
    $display("done regs");
  endtask
  task automatic t_sources;
    int         ids[5] = '{0, 1, 2, 3, 5};
    int         n;
    logic [7:0] en;
    foreach (ids[i]) begin
      en = 8'(1 << (ids[i] + 1));
      wr(8'h02, en | 8'h01);
      pulse(ids[i]);
      wait_vec(3'(ids[i]), 8, n);
      rdc(8'h03, 8'h00);
      rdc(8'h02, en);
      core_cmd(1'b0);
      rdc(8'h02, en | 8'h01);
    end
    $display("done sources");
  endtask
  task automatic t_prio;
    int n;
    slow <= 1'b1;
    wr(8'h02, 8'h00);
    wr(8'h03, 8'h3E);
    wr(8'h02, 8'h7F);
    for (int id = 1; id < 6; id++) begin
      wait_vec(3'(id), 12, n);
      core_cmd(1'b0);
    end
    wr(8'h02, 8'h00);
    slow <= 1'b0;
    $display("done priority");
  endtask
  // lo and hi: edges from the start write to the vector; the prescaler phase is free running
  task automatic tick_case(input logic [7:0] psc, input logic [7:0] sel, input int lo,
                           input int hi);
    int n;
    wr(8'h02, 8'h00);
    wr(8'h01, psc);
    wr(8'h02, 8'h21);
    wr(8'h00, 8'h80 | sel);
    wait_vec(3'h4, hi + 4, n);
    chk({7'h0, n >= lo && n <= hi}, 8'h01);
    wr(8'h00, 8'h00);
    core_cmd(1'b0);
  endtask
  task automatic t_tick;
    wr(8'h01, 8'h00);
    wr(8'h00, 8'h80);
    repeat (200) @(posedge CLK);
    wr(8'h00, 8'h00);
    tick_case(8'h00, 8'h00, 257, 257);
    tick_case(8'h01, 8'h01, 2046, 2049);
    tick_case(8'h00, 8'h02, 1025, 1025);
    tick_case(8'h02, 8'h00, 2042, 2049);
    tick_case(8'h03, 8'h00, 2042, 2049);
    tick_case(8'h00, 8'h07, 32769, 32769);
    $display("done time base");
  endtask
  task automatic t_gate;
    logic v, w;
    int   n;
    wr(8'h02, 8'h00);
    pulse(2);
    watch(6, v, w);
    chk({6'h0, v, w}, 8'h01);
    rdc(8'h03, 8'h04);
    // software presets the flag so the event cannot wake the device
    wr(8'h03, 8'h0C);
    watch(4, v, w);
    pulse(3);
    watch(6, v, w);
    chk({7'h0, w}, 8'h00);
    core_cmd(1'b1);
    wr(8'h02, 8'h09);
    watch(8, v, w);
    chk({7'h0, v}, 8'h00);
    core_cmd(1'b0);
    wait_vec(3'h2, 10, n);
    wr(8'h03, 8'h00);
    rdc(8'h03, 8'h00);
    $display("done gating");
  endtask
  // --------------------------------------------------------------
  // run control
  // --------------------------------------------------------------
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    SYS_RST = 1'b1;
    {WR, RD, slow, ret_req, nest_fill} = 5'h00;
    {ADDR, WDATA} = 16'h0000;
    ev = 6'h00;
    repeat (3) @(posedge CLK);
    SYS_RST <= 1'b0;
    t_regs();
    t_sources();
    t_prio();
    t_tick();
    t_gate();
    end_of_test();
  end
  // the tests need roughly 41000 cycles
  initial begin
    repeat (60000) @(posedge CLK);
    mismatches++;
    end_of_test();
  end
endmodule
